//--- lbr_consts.svh
/*
  Constants for the logic block output routing and clocking block:
  register offsets, field positions, reset values and fixed sizes.
  Assumes it is included by its bare name and only holds definitions.
*/
`ifndef LBR_CONSTS_SVH
`define LBR_CONSTS_SVH

`define LBR_NUM_MC          16
`define LBR_NUM_IO          8
`define LBR_NUM_BCLK        4
`define LBR_ADDR_W          8
`define LBR_DATA_W          16

`define LBR_CTRL_OFS        8'h00
`define LBR_CLKSEL_OFS      8'h04
`define LBR_STATUS_OFS      8'h08
`define LBR_ISM_OFS         8'h0C
`define LBR_IOCFG_BASE      8'h20
`define LBR_IOCFG_PAGE      3'h1

`define LBR_CTRL_ONE2ONE    0
`define LBR_CTRL_TWOPIN     1
`define LBR_CLK_CFG_W       2
`define LBR_IOCFG_W         6
`define LBR_ISM_SEL_W       2

`define LBR_CTRL_RST        2'h0
`define LBR_CLKSEL_RST      8'h00
`define LBR_IOCFG_RST       6'h00
`define LBR_ISM_RST         16'h0000

`endif

//--- lbr_pkg.sv
/*
  Types for the logic block output routing and clocking block.
  Assumes lbr_consts.svh is on the include path.
*/
`default_nettype none
`include "lbr_consts.svh"

package lbr_pkg;

  // software command port, one strobe per cycle
  typedef struct packed {
    logic [`LBR_ADDR_W-1:0] addr;
    logic [`LBR_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } lbr_bus_req_t;

  // per block clock: pick one of two global clocks, optionally inverted
  typedef struct packed {
    logic inv;
    logic src;
  } lbr_clk_cfg_t;

  // per I/O cell: driver choice, storage kind, storage clock choice
  typedef struct packed {
    logic [1:0] clk_sel;
    logic       latch;
    logic [2:0] sel;
  } lbr_io_cfg_t;

endpackage : lbr_pkg

`default_nettype wire

//--- lbr_block.sv
/*
  Output switch matrix, I/O cells, input switch matrix lanes and block
  clock generator of one programmable logic block, with a config port.
  Assumes every input is synchronous to clock; global clock pins are
  sampled as plain levels, so block clocks run far below 25 MHz.
*/
// Our own choices: the address-and-strobe port and the register addresses.
`default_nettype none
`include "lbr_consts.svh"

module lbr_block (
  input  wire logic                         clock,
  input  wire logic                         sys_rst,
  input  wire lbr_pkg::lbr_bus_req_t        bus_req,
  output var  logic [`LBR_DATA_W-1:0]       rd_data,
  input  wire logic [`LBR_NUM_MC-1:0]       mc_out,
  input  wire logic [`LBR_NUM_IO-1:0]       oe_term,
  input  wire logic [`LBR_NUM_IO-1:0]       pin_in,
  input  wire logic                         global_clock_pin_0,
  input  wire logic                         global_clock_pin_1,
  input  wire logic                         global_clock_pin_2,
  input  wire logic                         global_clock_pin_3,
  input  wire logic                         async_reset_term,
  input  wire logic                         async_preset_term,
  output var  logic [`LBR_NUM_IO-1:0]       pin_out,
  output var  logic [`LBR_NUM_IO-1:0]       pin_oe,
  output var  logic [`LBR_NUM_IO-1:0]       fb_direct,
  output var  logic [`LBR_NUM_IO-1:0]       fb_stored,
  output var  logic [`LBR_NUM_IO-1:0]       csm_lane,
  output var  logic                         block_clock_0,
  output var  logic                         block_clock_1,
  output var  logic                         block_clock_2,
  output var  logic                         block_clock_3
);
  import lbr_pkg::*;

  logic                            one_to_one_ff;
  logic                            nxt_one_to_one;
  logic                            two_pin_ff;
  logic                            nxt_two_pin;
  lbr_clk_cfg_t [`LBR_NUM_BCLK-1:0] clk_cfg_ff;
  lbr_clk_cfg_t [`LBR_NUM_BCLK-1:0] nxt_clk_cfg;
  lbr_io_cfg_t  [`LBR_NUM_IO-1:0]   io_cfg_ff;
  lbr_io_cfg_t  [`LBR_NUM_IO-1:0]   nxt_io_cfg;
  logic [`LBR_DATA_W-1:0]          ism_sel_ff;
  logic [`LBR_DATA_W-1:0]          nxt_ism_sel;
  logic [`LBR_DATA_W-1:0]          rd_data_ff;
  logic [`LBR_DATA_W-1:0]          nxt_rd_data;
  logic [`LBR_NUM_BCLK-1:0]        bclk_ff;
  logic [`LBR_NUM_BCLK-1:0]        nxt_bclk;
  logic [`LBR_NUM_BCLK-1:0]        bclk_prev_ff;
  logic [`LBR_NUM_BCLK-1:0]        gclk;
  logic [`LBR_NUM_IO-1:0]          pin_out_ff;
  logic [`LBR_NUM_IO-1:0]          nxt_pin_out;
  logic [`LBR_NUM_IO-1:0]          pin_oe_ff;
  logic [`LBR_NUM_IO-1:0]          fb_direct_ff;
  logic [`LBR_NUM_IO-1:0]          store_ff;
  logic [`LBR_NUM_IO-1:0]          nxt_store;
  logic [`LBR_NUM_IO-1:0]          lane_ff;
  logic [`LBR_NUM_IO-1:0]          nxt_lane;
  logic [3:0]                      mc_idx [`LBR_NUM_IO];
  logic                            iocfg_hit;

  assign iocfg_hit = (bus_req.addr[7:5] == `LBR_IOCFG_PAGE) && (bus_req.addr[1:0] == 2'h0);

  // configuration registers and read port
  always_comb begin
    nxt_one_to_one = one_to_one_ff;
    nxt_two_pin    = two_pin_ff;
    nxt_clk_cfg    = clk_cfg_ff;
    nxt_io_cfg     = io_cfg_ff;
    nxt_ism_sel    = ism_sel_ff;
    nxt_rd_data    = '0;
    if (bus_req.wr) begin
      if (bus_req.addr == `LBR_CTRL_OFS) begin
        nxt_one_to_one = bus_req.wdata[`LBR_CTRL_ONE2ONE];
        nxt_two_pin    = bus_req.wdata[`LBR_CTRL_TWOPIN];
      end else if (bus_req.addr == `LBR_CLKSEL_OFS) begin
        nxt_clk_cfg = bus_req.wdata[`LBR_NUM_BCLK*`LBR_CLK_CFG_W-1:0];
      end else if (bus_req.addr == `LBR_ISM_OFS) begin
        nxt_ism_sel = bus_req.wdata;
      end else if (iocfg_hit) begin
        nxt_io_cfg[bus_req.addr[4:2]] = lbr_io_cfg_t'(bus_req.wdata[`LBR_IOCFG_W-1:0]);
      end
    end
    if (bus_req.rd) begin
      if (bus_req.addr == `LBR_CTRL_OFS) begin
        nxt_rd_data = {14'h0000, two_pin_ff, one_to_one_ff};
      end else if (bus_req.addr == `LBR_CLKSEL_OFS) begin
        nxt_rd_data = {8'h00, clk_cfg_ff};
      end else if (bus_req.addr == `LBR_STATUS_OFS) begin
        nxt_rd_data = {store_ff, fb_direct_ff};
      end else if (bus_req.addr == `LBR_ISM_OFS) begin
        nxt_rd_data = ism_sel_ff;
      end else if (iocfg_hit) begin
        nxt_rd_data = {10'h000, io_cfg_ff[bus_req.addr[4:2]]};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      {two_pin_ff, one_to_one_ff} <= `LBR_CTRL_RST;
      clk_cfg_ff    <= `LBR_CLKSEL_RST;
      io_cfg_ff     <= {`LBR_NUM_IO{`LBR_IOCFG_RST}};
      ism_sel_ff    <= `LBR_ISM_RST;
      rd_data_ff    <= '0;
    end else begin
      one_to_one_ff <= nxt_one_to_one;
      two_pin_ff    <= nxt_two_pin;
      clk_cfg_ff    <= nxt_clk_cfg;
      io_cfg_ff     <= nxt_io_cfg;
      ism_sel_ff    <= nxt_ism_sel;
      rd_data_ff    <= nxt_rd_data;
    end
  end

  // missing pins follow 0 and 1
  always_comb begin
    gclk[0] = global_clock_pin_0;
    gclk[1] = global_clock_pin_1;
    gclk[2] = two_pin_ff ? global_clock_pin_0 : global_clock_pin_2;
    gclk[3] = two_pin_ff ? global_clock_pin_1 : global_clock_pin_3;
  end

  genvar k;
  generate
    for (k = 0; k < `LBR_NUM_BCLK; k++) begin : g_bclk
      always_comb begin
        nxt_bclk[k] = (clk_cfg_ff[k].src ? gclk[(k/2)*2+1] : gclk[(k/2)*2]) ^ clk_cfg_ff[k].inv;
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bclk_ff      <= '0;
      bclk_prev_ff <= '0;
    end else begin
      bclk_ff      <= nxt_bclk;
      bclk_prev_ff <= bclk_ff;
    end
  end

  genvar c;
  generate
    for (c = 0; c < `LBR_NUM_IO; c++) begin : g_cell
      logic [2:0] pair;
      logic       sclk;
      logic       srise;
      always_comb begin
        // one driver per cell, pairs c..c+3
        pair = 3'(c) + {1'b0, io_cfg_ff[c].sel[2:1]};
        // whole group of eight in 1:1 mode
        mc_idx[c] = one_to_one_ff ? {1'b0, io_cfg_ff[c].sel} : {pair, io_cfg_ff[c].sel[0]};
        nxt_pin_out[c] = mc_out[mc_idx[c]];
        sclk  = bclk_ff[io_cfg_ff[c].clk_sel];
        srise = sclk & ~bclk_prev_ff[io_cfg_ff[c].clk_sel];
        nxt_store[c] = store_ff[c];
        if (one_to_one_ff) begin
          nxt_store[c] = 1'b0;
        end else if (io_cfg_ff[c].latch) begin
          if (!sclk) begin
            nxt_store[c] = pin_in[c];
          end
        end else if (async_reset_term) begin
          // reset wins when both terms are high
          nxt_store[c] = 1'b0;
        end else if (async_preset_term) begin
          nxt_store[c] = 1'b1;
        end else if (srise) begin
          nxt_store[c] = pin_in[c];
        end
        // each lane picks one of four feedbacks
        unique case (ism_sel_ff[c*2 +: 2])
          2'h0: nxt_lane[c] = fb_direct_ff[c];
          2'h1: nxt_lane[c] = store_ff[c];
          2'h2: nxt_lane[c] = fb_direct_ff[(c+1)%`LBR_NUM_IO];
          2'h3: nxt_lane[c] = store_ff[(c+1)%`LBR_NUM_IO];
        endcase
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_out_ff   <= '0;
      pin_oe_ff    <= '0;
      fb_direct_ff <= '0;
      store_ff     <= '0;
      lane_ff      <= '0;
    end else begin
      pin_out_ff   <= nxt_pin_out;
      // per-cell enable, pin always fed back
      pin_oe_ff    <= oe_term;
      fb_direct_ff <= pin_in;
      store_ff     <= nxt_store;
      lane_ff      <= nxt_lane;
    end
  end

  assign rd_data       = rd_data_ff;
  assign pin_out       = pin_out_ff;
  assign pin_oe        = pin_oe_ff;
  assign fb_direct     = fb_direct_ff;
  assign fb_stored     = store_ff;
  assign csm_lane      = lane_ff;
  assign block_clock_0 = bclk_ff[0];
  assign block_clock_1 = bclk_ff[1];
  assign block_clock_2 = bclk_ff[2];
  assign block_clock_3 = bclk_ff[3];

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  generate
    for (c = 0; c < `LBR_NUM_IO; c++) begin : g_chk
      route_window_a: assert property (
        !one_to_one_ff |-> (3'(mc_idx[c][3:1] - 3'(c)) <= 3'h3))
        else $error("cell driver outside its four pairs");
      route_group_a: assert property (
        one_to_one_ff |=> pin_out[c] == $past(mc_out[{1'b0, io_cfg_ff[c].sel}]))
        else $error("1:1 driver not from low group");
    end
  endgenerate

  oe_follow_a: assert property (
    ##1 pin_oe == $past(oe_term))
    else $error("pin enable not following its term");
  feedback_pass_a: assert property (
    !oe_term[0] |=> fb_direct[0] == $past(pin_in[0]) && !pin_oe[0])
    else $error("feedback lost while driver off");

  sequence s_cell0_open;
    !one_to_one_ff && io_cfg_ff[0].latch && !bclk_ff[io_cfg_ff[0].clk_sel];
  endsequence
  latch_ignore_a: assert property (
    s_cell0_open ##0 (async_reset_term || async_preset_term) |=> fb_stored[0] == $past(pin_in[0]))
    else $error("latch obeyed reset or preset");

  sequence s_rise0;
    !bclk_ff[0] ##1 bclk_ff[0];
  endsequence
  sequence s_reg0_quiet;
    !one_to_one_ff && !io_cfg_ff[0].latch && io_cfg_ff[0].clk_sel == 2'h0
      && !async_reset_term && !async_preset_term;
  endsequence
  reg_capture_a: assert property (
    s_rise0 ##0 s_reg0_quiet |=> fb_stored[0] == $past(pin_in[0]))
    else $error("register missed block clock edge");
  store_absent_a: assert property (
    one_to_one_ff |=> fb_stored == '0)
    else $error("storage active in 1:1 mode");
  reset_wins_a: assert property (
    !one_to_one_ff && !io_cfg_ff[0].latch && async_reset_term |=> !fb_stored[0])
    else $error("register not cleared by reset term");
  lane_route_a: assert property (
    ism_sel_ff[1:0] == 2'h1 |=> csm_lane[0] == $past(fb_stored[0]))
    else $error("lane not carrying stored copy");
  clk_follow_a: assert property (
    two_pin_ff && clk_cfg_ff[2] == 2'h0 |=> block_clock_2 == $past(global_clock_pin_0))
    else $error("block clock 2 not following pin 0");
  clk_invert_a: assert property (
    clk_cfg_ff[1] == 2'h2 |=> block_clock_1 == !$past(global_clock_pin_0))
    else $error("inverted block clock wrong");
  clk_pass_a: assert property (
    clk_cfg_ff[0] == 2'h1 |=> block_clock_0 == $past(global_clock_pin_1))
    else $error("block clock 0 not taking global 1");
  status_read_a: assert property (
    bus_req.rd && bus_req.addr == `LBR_STATUS_OFS |=> rd_data == $past({fb_stored, fb_direct}))
    else $error("status read lost a feedback copy");

  sequence s_cell0_shut;
    !one_to_one_ff && io_cfg_ff[0].latch && bclk_ff[io_cfg_ff[0].clk_sel];
  endsequence
  latch_hold_a: assert property (
    s_cell0_shut |=> fb_stored[0] == $past(fb_stored[0]))
    else $error("closed latch changed its value");

endmodule : lbr_block

`default_nettype wire

//--- lbr_pin_model.sv
/*
  Board-side model of the I/O pins of one logic block: resolves each
  wire from the block driver and an external driver owned by the bench.
  Assumes pin_out and pin_oe come from the block, ext_* from the bench.
*/
`default_nettype none
`include "lbr_consts.svh"

module lbr_pin_model (
  input  wire logic                   clock,
  input  wire logic [`LBR_NUM_IO-1:0] pin_out,
  input  wire logic [`LBR_NUM_IO-1:0] pin_oe,
  input  wire logic [`LBR_NUM_IO-1:0] ext_val,
  input  wire logic [`LBR_NUM_IO-1:0] ext_en,
  output var  logic [`LBR_NUM_IO-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [`LBR_NUM_IO-1:0] last_ff = 8'h00;

  // wire resolution
  // an undriven wire toggles each cycle so a stale value never passes
  always_comb begin
    for (int i = 0; i < `LBR_NUM_IO; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else pin_in[i] = ~last_ff[i];
    end
  end

  always @(posedge clock) begin
    last_ff <= pin_in;
  end
endmodule : lbr_pin_model

`default_nettype wire

//--- logic_block_io_clock_routing_tb.sv
/*
  Self-checking bench for lbr_block: config port, output routing,
  enables, feedback, input storage and block clock generation.
  Assumes lbr_pkg is compiled first and lbr_consts.svh is on the path.
*/
`default_nettype none
`include "lbr_consts.svh"

module logic_block_io_clock_routing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lbr_pkg::*;

  logic                   clock = 1'b0;
  logic                   sys_rst = 1'b1;
  lbr_bus_req_t           bus_req = '0;
  logic [15:0]            rd_data;
  logic [15:0]            mc_out = 16'h0000;
  logic [7:0]             oe_term = 8'h00;
  logic [7:0]             pin_in, pin_out, pin_oe, fb_direct, fb_stored, csm_lane;
  logic [7:0]             ext_val = 8'h00;
  logic [7:0]             ext_en = 8'hFF;
  logic [3:0]             gclk = 4'h0;
  logic                   ar = 1'b0;
  logic                   ap = 1'b0;
  logic [3:0]             bclk;
  int                     fails = 0;
  int                     checks = 0;
  logic [15:0]            rv;

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fails++; \
  $display("BAD %0t got %h want %h", $time, got, exp); end end

  always #20 clock = ~clock;

  lbr_block DUT (.clock(clock), .sys_rst(sys_rst), .bus_req(bus_req), .rd_data(rd_data),
    .mc_out(mc_out), .oe_term(oe_term), .pin_in(pin_in), .global_clock_pin_0(gclk[0]),
    .global_clock_pin_1(gclk[1]), .global_clock_pin_2(gclk[2]), .global_clock_pin_3(gclk[3]),
    .async_reset_term(ar), .async_preset_term(ap), .pin_out(pin_out), .pin_oe(pin_oe),
    .fb_direct(fb_direct), .fb_stored(fb_stored), .csm_lane(csm_lane),
    .block_clock_0(bclk[0]), .block_clock_1(bclk[1]), .block_clock_2(bclk[2]),
    .block_clock_3(bclk[3]));

  lbr_pin_model board (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
    .ext_en(ext_en), .pin_in(pin_in));

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd_reg

  task automatic t_reset_vals;
    rd_reg(`LBR_CLKSEL_OFS, rv); `CHK(rv, 16'h0000)
    rd_reg(`LBR_IOCFG_BASE, rv); `CHK(rv, 16'h0000)
    wr_reg(8'hF0, 16'hFFFF);
    rd_reg(8'hF0, rv); `CHK(rv, 16'h0000)
  endtask : t_reset_vals

  task automatic t_route(input logic one2one);
    logic [2:0] s;
    int         m;
    wr_reg(`LBR_CTRL_OFS, {15'h0000, one2one});
    for (int c = 0; c < 8; c++) begin
      s = one2one ? 3'(7 - c) : 3'(c);
      m = one2one ? int'(s) : 2 * ((c + int'(s[2:1])) % 8) + int'(s[0]);
      wr_reg(8'(`LBR_IOCFG_BASE + 4 * c), {13'h0000, s});
      mc_out <= 16'h0001 << m;
      tick(3);
      if (one2one) `CHK(pin_out[c], 1'b1)
      else `CHK(pin_out[c], 1'b1)
      mc_out <= ~(16'h0001 << m);
      tick(2);
      `CHK(pin_out[c], 1'b0)
    end
    wr_reg(`LBR_CTRL_OFS, 16'h0000);
  endtask : t_route

  task automatic t_oe_feedback;
    oe_term <= 8'h0F;
    ext_en  <= 8'hF0;
    ext_val <= 8'hA0;
    // cells 0..3 pick macrocells 7, 8, 9, 10 with the sel values left by t_route
    mc_out  <= 16'h0280;
    wr_reg(`LBR_ISM_OFS, 16'hAAAA);
    tick(4);
    `CHK(pin_oe, 8'h0F)
    `CHK(pin_out[3:0], 4'h5)
    `CHK(fb_direct, 8'hA5)
    `CHK(csm_lane, 8'hD2)
    wr_reg(`LBR_ISM_OFS, 16'h0000);
    tick(3);
    `CHK(csm_lane, 8'hA5)
    mc_out  <= 16'h0000;
    oe_term <= 8'h00;
    ext_en  <= 8'hFF;
  endtask : t_oe_feedback

  task automatic t_storage;
    ext_val <= 8'h01;
    wr_reg(`LBR_IOCFG_BASE, 16'h0000);
    gclk <= 4'h1;
    tick(4);
    `CHK(fb_stored[0], 1'b1)
    ext_val <= 8'h00;
    tick(4);
    rd_reg(`LBR_STATUS_OFS, rv); `CHK(rv[8], 1'b1)
    `CHK(rv[0], 1'b0)
    // lane 0 takes stored copy 0, lane 7 the neighbour's stored copy
    wr_reg(`LBR_ISM_OFS, 16'hC001);
    tick(2);
    `CHK(csm_lane, 8'h81)
    ar <= 1'b1;
    ap <= 1'b1;
    tick(3);
    `CHK(fb_stored[0], 1'b0)
    wr_reg(`LBR_IOCFG_BASE, 16'h0008);
    ext_val <= 8'h01;
    tick(4);
    `CHK(fb_stored[0], 1'b0)
    gclk <= 4'h0;
    tick(4);
    `CHK(fb_stored[0], 1'b1)
    ar <= 1'b0;
    ap <= 1'b0;
    wr_reg(`LBR_CTRL_OFS, 16'h0001);
    tick(4);
    `CHK(fb_stored, 8'h00)
    // reconfigure while storage is still forced to zero, so no latch opens
    wr_reg(`LBR_IOCFG_BASE, 16'h0030);
    wr_reg(`LBR_CTRL_OFS, 16'h0000);
    gclk <= 4'h1;
    tick(4);
    `CHK(fb_stored[0], 1'b0)
    gclk <= 4'h5;
    tick(4);
    `CHK(fb_stored[0], 1'b1)
  endtask : t_storage

  task automatic t_clocks;
    logic [3:0] g;
    logic [3:0] e;
    gclk <= 4'b1001;
    for (int tp = 0; tp < 2; tp++) begin
      wr_reg(`LBR_CTRL_OFS, 16'(tp * 2));
      for (int cfg = 0; cfg < 4; cfg++) begin
        g = tp ? 4'b0101 : 4'b1001;
        wr_reg(`LBR_CLKSEL_OFS, {8'h00, {4{cfg[1:0]}}});
        tick(3);
        e[1:0] = {2{(cfg[0] ? g[1] : g[0]) ^ cfg[1]}};
        e[3:2] = {2{(cfg[0] ? g[3] : g[2]) ^ cfg[1]}};
        `CHK(bclk, e)
      end
    end
    gclk <= 4'h0;
  endtask : t_clocks

  task automatic final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  initial begin
    #200000;
    fails++;
    final_report();
  end

  initial begin
    tick(3);
    sys_rst <= 1'b0;
    tick(1);
    `CHK(fb_stored, 8'h00)
    t_reset_vals();
    t_route(1'b0);
    t_route(1'b1);
    t_oe_feedback();
    t_storage();
    t_clocks();
    final_report();
  end
endmodule : logic_block_io_clock_routing_tb

`default_nettype wire
